// file: rtl/mpbc_controller.sv
// Memory and peripheral bus controller with an APB register port.
`timescale 1ns/10ps
`include "mpbc_cfg.svh"

// How it works
// - Pins with a low suffix assert low; all others assert high.
// - read_not_write is high for reads, low for writes, whole transaction.
// - Read output strobe asserts while the external device should drive data.
// - Four low-active device selects; exactly one asserts per transaction.
// - Dedicated 22-bit address output; upper address bits live elsewhere.
// - Data pins are inputs during cold reset and load the boot vector.
// - Buffer direction follows the read or write direction of each transaction.
// - External buffer enabled only while a transaction needs it.
// - Write strobe is the write enable for write transactions.
// - Programmable 0 to 63 wait states and 0 to 31 post delay.
// - Writes to a chip select that is write-protected when the command is accepted are never performed.
// - Transaction timer raises warm reset when it expires first.
module mpbc_controller
    import mpbc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [21:0] bus_address,
    input  wire logic [7:0]  bus_data_in,
    output logic      [7:0]  bus_data_out,
    output logic             bus_data_oe_low,
    output logic      [3:0]  device_selects_n,
    output logic             read_output_strobe_n,
    output logic             bus_write_strobe_n,
    output logic             read_not_write,
    output logic             buf_direction_low,
    output logic             buffer_output_enable_low,
    input  wire logic        wait_or_ack_in_n,
    output logic             warm_reset
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    mpbc_state_type  state;
    mpbc_cs_cfg_type cs_cfg [4];
    mpbc_cmd_type    cmd;
    mpbc_cs_cfg_type act_cfg;
    logic [15:0]     timeout_limit;
    logic [15:0]     timer;
    logic [7:0]      write_data;
    logic [7:0]      read_data;
    logic [7:0]      boot_vector;
    logic            boot_pending;
    logic            wp_error;
    logic            timeout_flag;
    logic            wr_access;
    logic            cmd_write;
    logic            start;
    logic            wp_reject;
    logic            cnt_zero;
    logic            finish;
    logic            timeout_hit;
    logic            cnt_load;
    logic [5:0]      cnt_value;
    logic [31:0]     rd_word;

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a[1:0] == 2'b00) && (a <= `MPBC_OFF_STATUS);
    endfunction

    assign act_cfg = cs_cfg[cmd.sel];

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    assign pready    = 1'b1;
    assign wr_access = psel && penable && pwrite && addr_mapped(paddr);
    assign cmd_write = wr_access && (paddr == `MPBC_OFF_CMD);
    assign pslverr   = psel && penable && (!addr_mapped(paddr) || (cmd_write && state != MPBC_IDLE));

    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr <= `MPBC_OFF_CSCFG3) begin
            rd_word[`MPBC_CFG_WS_LSB +: 6]   = cs_cfg[paddr[3:2]].wait_states;
            rd_word[`MPBC_CFG_POST_LSB +: 5] = cs_cfg[paddr[3:2]].post_delay;
            rd_word[`MPBC_CFG_WP_BIT]        = cs_cfg[paddr[3:2]].write_protect;
            rd_word[`MPBC_CFG_ACK_BIT]       = cs_cfg[paddr[3:2]].ack_mode;
        end else if (paddr == `MPBC_OFF_TIMEOUT) begin
            rd_word[15:0] = timeout_limit;
        end else if (paddr == `MPBC_OFF_CMD) begin
            rd_word[24:0] = cmd;
        end else if (paddr == `MPBC_OFF_DATA) begin
            rd_word[7:0] = read_data;
        end else if (paddr == `MPBC_OFF_STATUS) begin
            rd_word[`MPBC_ST_BUSY_BIT]      = (state != MPBC_IDLE);
            rd_word[`MPBC_ST_WPERR_BIT]     = wp_error;
            rd_word[`MPBC_ST_TMO_BIT]       = timeout_flag;
            rd_word[`MPBC_ST_BOOT_LSB +: 8] = boot_vector;
        end
    end

    // Read data is sampled in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= addr_mapped(paddr) ? rd_word : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                cs_cfg[i] <= '{ack_mode: 1'b0, write_protect: 1'b0, post_delay: 5'h00,
                               wait_states: `MPBC_CSCFG_RESET};
            end
        end else if (wr_access && paddr <= `MPBC_OFF_CSCFG3) begin
            cs_cfg[paddr[3:2]] <= '{ack_mode:      pwdata[`MPBC_CFG_ACK_BIT],
                                   write_protect: pwdata[`MPBC_CFG_WP_BIT],
                                   post_delay:    pwdata[`MPBC_CFG_POST_LSB +: 5],
                                   wait_states:   pwdata[`MPBC_CFG_WS_LSB +: 6]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_limit <= `MPBC_TIMEOUT_RESET;
        end else if (wr_access && paddr == `MPBC_OFF_TIMEOUT) begin
            timeout_limit <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_data <= 8'h00;
        end else if (wr_access && paddr == `MPBC_OFF_DATA) begin
            write_data <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Command acceptance and status flags
    // ------------------------------------------------------------------------
    assign wp_reject = cmd_write && state == MPBC_IDLE && !pwdata[`MPBC_CMD_READ_BIT]
                       && cs_cfg[pwdata[`MPBC_CMD_SEL_LSB +: 2]].write_protect;
    assign start     = cmd_write && state == MPBC_IDLE && !wp_reject;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= '{is_read: 1'b1, sel: 2'b00, addr: 22'h000000};
        end else if (start) begin
            cmd <= pwdata[24:0];
        end
    end

    // Status bits clear on a write of one; a new event in that cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_error     <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            wp_error     <= wp_reject ||
                            (wp_error && !(wr_access && paddr == `MPBC_OFF_STATUS && pwdata[`MPBC_ST_WPERR_BIT]));
            timeout_flag <= timeout_hit ||
                            (timeout_flag && !(wr_access && paddr == `MPBC_OFF_STATUS && pwdata[`MPBC_ST_TMO_BIT]));
        end
    end

    // The data pins are never driven in reset, so the first edge after release sees the boot straps.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_pending <= 1'b1;
            boot_vector  <= 8'h00;
        end else if (boot_pending) begin
            boot_pending <= 1'b0;
            boot_vector  <= bus_data_in;
        end
    end

    // ------------------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------------------
    assign finish      = state == MPBC_STROBE && cnt_zero && !timeout_hit &&
                         (act_cfg.ack_mode ? !wait_or_ack_in_n : wait_or_ack_in_n);
    assign timeout_hit = state == MPBC_STROBE && timeout_limit != 16'h0000 && timer >= timeout_limit;
    assign cnt_load    = start || finish;
    assign cnt_value   = start ? cs_cfg[pwdata[`MPBC_CMD_SEL_LSB +: 2]].wait_states
                               : {1'b0, act_cfg.post_delay - 5'h01};

    mpbc_delay_counter u_delay (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (cnt_load),
        .load_value (cnt_value),
        .count      (state != MPBC_IDLE),
        .is_zero    (cnt_zero)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MPBC_IDLE;
        end else begin
            case (state)
                MPBC_IDLE: begin
                    if (start) begin
                        state <= MPBC_STROBE;
                    end
                end
                MPBC_STROBE: begin
                    if (timeout_hit) begin
                        state <= MPBC_IDLE;
                    end else if (finish) begin
                        state <= (act_cfg.post_delay == 5'h00) ? MPBC_IDLE : MPBC_POST;
                    end
                end
                MPBC_POST: begin
                    if (cnt_zero) begin
                        state <= MPBC_IDLE;
                    end
                end
                default: begin
                    state <= MPBC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer <= 16'h0000;
        end else if (start) begin
            timer <= 16'h0000;
        end else if (state == MPBC_STROBE && timer != 16'hFFFF) begin
            timer <= timer + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_reset <= 1'b0;
        end else begin
            warm_reset <= timeout_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data <= 8'h00;
        end else if (finish && cmd.is_read) begin
            read_data <= bus_data_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_address  <= 22'h000000;
            bus_data_out <= 8'h00;
        end else if (start) begin
            bus_address  <= pwdata[21:0];
            bus_data_out <= write_data;
        end
    end

    // ------------------------------------------------------------------------
    // Pin strobes, all low-active except read_not_write
    // ------------------------------------------------------------------------
    always_comb begin
        device_selects_n         = 4'hF;
        read_output_strobe_n     = 1'b1;
        bus_write_strobe_n       = 1'b1;
        buffer_output_enable_low = 1'b1;
        if (state == MPBC_STROBE) begin
            device_selects_n         = ~(4'h1 << cmd.sel);
            read_output_strobe_n     = !cmd.is_read;
            bus_write_strobe_n       = cmd.is_read;
            buffer_output_enable_low = 1'b0;
        end
    end

    assign read_not_write    = cmd.is_read;
    assign buf_direction_low = !cmd.is_read;
    assign bus_data_oe_low   = !(state == MPBC_STROBE && !cmd.is_read);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_one_select;
        state == MPBC_STROBE |-> $onehot(~device_selects_n) && !device_selects_n[cmd.sel];
    endproperty
    a_one_select: assert property (p_one_select) else $error("Select not one-hot");

    property p_quiet;
        state != MPBC_STROBE |-> device_selects_n == 4'hF && read_output_strobe_n && bus_write_strobe_n
                                 && buffer_output_enable_low;
    endproperty
    a_quiet: assert property (p_quiet) else $error("Strobe active outside transaction");

    property p_rnw_stable;
        state == MPBC_STROBE && $past(state) == MPBC_STROBE |-> $stable(read_not_write);
    endproperty
    a_rnw_stable: assert property (p_rnw_stable) else $error("Direction changed mid transaction");

    property p_read_strobe;
        !read_output_strobe_n |-> read_not_write && bus_data_oe_low && bus_write_strobe_n;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("Read strobe with driven bus");

    property p_write_strobe;
        !bus_write_strobe_n |-> !read_not_write && !bus_data_oe_low && !act_cfg.write_protect;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("Bad write strobe");

    property p_direction;
        !buffer_output_enable_low |-> buf_direction_low == !read_not_write;
    endproperty
    a_direction: assert property (p_direction) else $error("Buffer direction wrong");

    property p_wait_states;
        state == MPBC_STROBE && !cnt_zero && !timeout_hit |=> state == MPBC_STROBE;
    endproperty
    a_wait_states: assert property (p_wait_states) else $error("Wait states cut short");

    property p_wait_extend;
        state == MPBC_STROBE && cnt_zero && !act_cfg.ack_mode && !wait_or_ack_in_n && !timeout_hit
            |=> state == MPBC_STROBE;
    endproperty
    a_wait_extend: assert property (p_wait_extend) else $error("Wait input ignored");

    property p_ack_end;
        state == MPBC_STROBE && cnt_zero && act_cfg.ack_mode && !wait_or_ack_in_n |=> state != MPBC_STROBE;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("Acknowledge ignored");

    property p_timeout;
        timeout_hit |=> warm_reset && state == MPBC_IDLE ##1 !warm_reset;
    endproperty
    a_timeout: assert property (p_timeout) else $error("Timer expiry not handled");

    property p_boot;
        boot_pending |=> !boot_pending && boot_vector == $past(bus_data_in) && bus_data_oe_low;
    endproperty
    a_boot: assert property (p_boot) else $error("Boot vector not captured");

    property p_wp_reject;
        wp_reject |=> state == MPBC_IDLE && wp_error;
    endproperty
    a_wp_reject: assert property (p_wp_reject) else $error("Protected write performed");

    c_read_done:  cover property (state == MPBC_STROBE && finish && cmd.is_read);
    c_write_done: cover property (state == MPBC_STROBE && finish && !cmd.is_read);
    c_post_delay: cover property (state == MPBC_POST ##1 state == MPBC_IDLE);
    c_timeout:    cover property (timeout_hit);

endmodule // mpbc_controller

// file: rtl/mpbc_cfg.svh
// Offsets, field positions and reset values of the memory and peripheral bus controller.
`ifndef MPBC_CFG_SVH
`define MPBC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MPBC_OFF_CSCFG0    12'h000
`define MPBC_OFF_CSCFG3    12'h00C
`define MPBC_OFF_TIMEOUT   12'h010
`define MPBC_OFF_CMD       12'h014
`define MPBC_OFF_DATA      12'h018
`define MPBC_OFF_STATUS    12'h01C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MPBC_CFG_WS_LSB    0
`define MPBC_CFG_POST_LSB  8
`define MPBC_CFG_WP_BIT    16
`define MPBC_CFG_ACK_BIT   17
`define MPBC_CMD_SEL_LSB   22
`define MPBC_CMD_READ_BIT  24
`define MPBC_ST_BUSY_BIT   0
`define MPBC_ST_WPERR_BIT  1
`define MPBC_ST_TMO_BIT    2
`define MPBC_ST_BOOT_LSB   8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MPBC_CSCFG_RESET   6'h3F
`define MPBC_TIMEOUT_RESET 16'h0400

`endif

// file: rtl/mpbc_pkg.sv
// Types shared by the memory and peripheral bus controller.
package mpbc_pkg;

    typedef enum logic [2:0] {
        MPBC_IDLE   = 3'b001,
        MPBC_STROBE = 3'b010,
        MPBC_POST   = 3'b100
    } mpbc_state_type;

    typedef struct packed {
        logic       ack_mode;
        logic       write_protect;
        logic [4:0] post_delay;
        logic [5:0] wait_states;
    } mpbc_cs_cfg_type;

    typedef struct packed {
        logic        is_read;
        logic [1:0]  sel;
        logic [21:0] addr;
    } mpbc_cmd_type;

endpackage

// file: rtl/mpbc_delay_counter.sv
// Loadable down counter used for wait states and post-access delay.
`timescale 1ns/10ps
module mpbc_delay_counter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [5:0] load_value,
    input  wire logic       count,
    output logic            is_zero
);

    logic [5:0] value;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= 6'h00;
        end else if (load) begin
            value <= load_value;
        end else if (count && value != 6'h00) begin
            value <= value - 6'h01;
        end
    end

    assign is_zero = (value == 6'h00);

endmodule // mpbc_delay_counter

// file: testbench/mpbc_ext_device.sv
// Behavioural external memory device that answers on the memory and peripheral bus.
`timescale 1ns/10ps
module mpbc_ext_device (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  device_selects_n,
    input  wire logic        read_output_strobe_n,
    input  wire logic        bus_write_strobe_n,
    input  wire logic [21:0] bus_address,
    input  wire logic [7:0]  bus_data_out,
    input  wire logic        bus_data_oe_low,
    input  wire logic        ack_mode,
    input  wire logic [7:0]  hold_cycles,
    input  wire logic [7:0]  boot_vector,
    output logic      [7:0]  bus_data_in,
    output logic             wait_or_ack_in_n,
    output logic      [7:0]  last_write,
    output logic      [7:0]  write_count
);
    logic [7:0] cnt;
    logic [7:0] junk;
    logic       booted;
    logic       active;

    assign active = (device_selects_n != 4'hF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt         <= 8'h00;
            junk        <= 8'hA5;
            booted      <= 1'b0;
            last_write  <= 8'h00;
            write_count <= 8'h00;
        end else begin
            booted <= 1'b1;
            junk   <= junk + 8'h3B;
            cnt    <= active ? cnt + 8'h01 : 8'h00;
            if (active && !bus_write_strobe_n && !bus_data_oe_low) begin
                last_write <= bus_data_out;
                if (cnt == 8'h00) begin
                    write_count <= write_count + 8'h01;
                end
            end
        end
    end

    // A released data bus shows a changing pattern, never the last value.
    assign bus_data_in = !booted ? boot_vector :
                         (active && !read_output_strobe_n) ? (bus_address[7:0] ^ 8'h5A) : junk;

    // Wait stretches the cycle for hold_cycles; acknowledge comes after hold_cycles.
    assign wait_or_ack_in_n = !active ? 1'b1 : ack_mode ? (cnt < hold_cycles) : (cnt >= hold_cycles);
endmodule // mpbc_ext_device

// file: testbench/tb_top.sv
// Self-checking testbench of the memory and peripheral bus controller.
`timescale 1ns/10ps
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, bus_data_oe_low, warm_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [21:0] bus_address;
    logic [7:0]  bus_data_in, bus_data_out, boot, hold, last_write, write_count;
    logic [3:0]  device_selects_n, exp_cs;
    logic        read_output_strobe_n, bus_write_strobe_n, read_not_write, buf_direction_low;
    logic        buffer_output_enable_low, wait_or_ack_in_n, ack_m, exp_rnw;
    logic [31:0] rng = 32'h00016E9E;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          strb_len, warm_cnt;
    logic [7:0]  exp_q[$];

    always #2.5 pclk = ~pclk;

    mpbc_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_address(bus_address), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
        .bus_data_oe_low(bus_data_oe_low), .device_selects_n(device_selects_n),
        .read_output_strobe_n(read_output_strobe_n), .bus_write_strobe_n(bus_write_strobe_n),
        .read_not_write(read_not_write), .buf_direction_low(buf_direction_low),
        .buffer_output_enable_low(buffer_output_enable_low), .wait_or_ack_in_n(wait_or_ack_in_n),
        .warm_reset(warm_reset));

    mpbc_ext_device ext (.pclk(pclk), .presetn(presetn), .device_selects_n(device_selects_n),
        .read_output_strobe_n(read_output_strobe_n), .bus_write_strobe_n(bus_write_strobe_n),
        .bus_address(bus_address), .bus_data_out(bus_data_out), .bus_data_oe_low(bus_data_oe_low),
        .ack_mode(ack_m), .hold_cycles(hold), .boot_vector(boot), .bus_data_in(bus_data_in),
        .wait_or_ack_in_n(wait_or_ack_in_n), .last_write(last_write), .write_count(write_count));

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) check("ready", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_idle();
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        do begin
            apb(1'b0, 12'h01C, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 200);
        if (r[0] !== 1'b0) check("busy timeout", 1'b0, r[0]);
    endtask

    // Strobe phase monitor: counts strobe cycles and checks the pins in every cycle.
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            if (warm_reset === 1'b1) warm_cnt++;
            if (device_selects_n !== 4'hF) begin
                strb_len++;
                check("selects", exp_cs, device_selects_n);
                check("strobes", {exp_rnw, ~exp_rnw, ~exp_rnw, exp_rnw, 1'b0, exp_rnw},
                      {read_not_write, buf_direction_low, read_output_strobe_n, bus_write_strobe_n,
                       buffer_output_enable_low, bus_data_oe_low});
            end else begin
                check("idle pins", 7'h7F, {device_selects_n, read_output_strobe_n, bus_write_strobe_n,
                      buffer_output_enable_low});
            end
        end
    end

    task automatic xact(input int sel, input logic is_rd, input int ws, input int post, input logic ack,
                        input int hd);
        logic [31:0] r;
        logic        e;
        logic [21:0] a;
        logic [7:0]  d;
        int          exp_len;
        a = 22'(rnd());
        d = 8'(rnd());
        apb(1'b1, 12'(sel * 4), {14'h0, ack, 1'b0, 3'h0, 5'(post), 2'h0, 6'(ws)}, r, e);
        if (!is_rd) apb(1'b1, 12'h018, {24'h0, d}, r, e);
        ack_m   <= ack;
        hold    <= 8'(hd);
        exp_rnw = is_rd;
        exp_cs  = ~(4'h1 << sel);
        strb_len = 0;
        apb(1'b1, 12'h014, {7'h0, is_rd, 2'(sel), a}, r, e);
        wait_idle();
        exp_len = ((ws > hd) ? ws : hd) + 1;
        check("strobe length", exp_len, strb_len);
        check("address", a, bus_address);
        if (is_rd) begin
            apb(1'b0, 12'h018, 32'h0, r, e);
            check("read byte", a[7:0] ^ 8'h5A, r[7:0]);
        end else begin
            exp_q.push_back(d);
            check("written byte", exp_q.pop_front(), last_write);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  wc;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ack_m = 1'b0;
        hold = 8'h00;
        exp_rnw = 1'b1;
        exp_cs = 4'hF;
        warm_cnt = 0;
        boot = 8'(rnd());
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("reset pins", 10'h3FE, {device_selects_n, read_output_strobe_n, bus_write_strobe_n,
              buffer_output_enable_low, read_not_write, bus_data_oe_low, warm_reset});
        apb(1'b0, 12'h01C, 32'h0, r, e);
        check("boot vector", {boot, 5'h0, 3'h0}, r[15:0]);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, r, e);
            check("wait state reset", 6'h3F, r[5:0]);
        end
        apb(1'b0, 12'h010, 32'h0, r, e);
        check("timer reset", 16'h0400, r[15:0]);
        apb(1'b0, 12'h020, 32'h0, r, e);
        check("unmapped error", 1'b1, e);
        check("unmapped data", 32'h0, r);
        apb(1'b1, 12'h002, 32'h0, r, e);
        check("misaligned", 1'b1, e);
        $display("reset and map test done");
        xact(0, 1'b0, 63, 31, 1'b0, 0);
        for (int i = 0; i < 16; i++) begin
            xact(i % 4, i[2], int'(rnd() % 8), int'(rnd() % 32), i[3], int'(rnd() % 12));
        end
        $display("transfer test done");
        wc = write_count;
        apb(1'b1, 12'h008, 32'h00010000, r, e);
        strb_len = 0;
        apb(1'b1, 12'h014, {7'h0, 1'b0, 2'h2, 22'h155}, r, e);
        wait_idle();
        apb(1'b0, 12'h01C, 32'h0, r, e);
        check("protected write", {8'h00, wc, 1'b1}, {strb_len[7:0], write_count, r[1]});
        apb(1'b1, 12'h01C, 32'h00000002, r, e);
        apb(1'b0, 12'h01C, 32'h0, r, e);
        check("protect flag clear", 1'b0, r[1]);
        $display("write protect test done");
        exp_rnw = 1'b1;
        exp_cs = 4'hD;
        apb(1'b1, 12'h004, 32'h00000028, r, e);
        apb(1'b1, 12'h014, {7'h0, 1'b1, 2'h1, 22'h0}, r, e);
        apb(1'b1, 12'h014, {7'h0, 1'b1, 2'h1, 22'h0}, r, e);
        check("busy refusal", 1'b1, e);
        wait_idle();
        $display("busy test done");
        apb(1'b1, 12'h010, 32'h00000008, r, e);
        apb(1'b1, 12'h000, 32'h00000000, r, e);
        hold <= 8'd100;
        ack_m <= 1'b0;
        exp_cs = 4'hE;
        strb_len = 0;
        warm_cnt = 0;
        apb(1'b1, 12'h014, {7'h0, 1'b1, 2'h0, 22'h0}, r, e);
        wait_idle();
        apb(1'b0, 12'h01C, 32'h0, r, e);
        check("timer expiry", 2'h3, {r[2], warm_cnt == 1});
        check("timer strobe length", 9, strb_len);
        apb(1'b1, 12'h01C, 32'h00000004, r, e);
        $display("timer test done");
        stop_test();
    end
endmodule // tb_top
